// file: core/mpgb_map.svh
/*
  Register offsets, reset values and option encodings of the multi-port GPIO block.
  Assumes a 16-bit byte address and 8-bit data on the register port.
*/
`ifndef MPGB_MAP_SVH
`define MPGB_MAP_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define MPGB_ADDR_NIB_LATCH 16'hFF02
`define MPGB_ADDR_SP_LATCH 16'hFF03
`define MPGB_ADDR_BYTE_LATCH 16'hFF04
`define MPGB_ADDR_NIB_DIR 16'hFF22
`define MPGB_ADDR_SP_DIR 16'hFF23
`define MPGB_ADDR_BYTE_DIR 16'hFF24
`define MPGB_ADDR_NIB_PU 16'hFF32
`define MPGB_ADDR_SP_PU 16'hFF33
`define MPGB_ADDR_BYTE_PU 16'hFF34
`define MPGB_ADDR_ANA_SEL 16'hFF84

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define MPGB_SP_IO_BIT 2
`define MPGB_SP_RST_BIT 4

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define MPGB_RST_DIR8 8'hFF
`define MPGB_RST_DIR4 4'hF
`define MPGB_RST_LATCH8 8'h00
`define MPGB_RST_LATCH4 4'h0
`define MPGB_RST_PU8 8'h00
`define MPGB_RST_PU4 4'h0
`define MPGB_RST_ANA4 4'h0

// ----------------------------------------------------------------------------
// option encodings and oscillator pin masks
// ----------------------------------------------------------------------------
`define MPGB_OPT_CLK_HSI 2'h0
`define MPGB_OPT_CLK_XTAL 2'h1
`define MPGB_OPT_CLK_EXT 2'h2
`define MPGB_CLAIM_XTAL 4'hC
`define MPGB_CLAIM_EXT 4'h8
`define MPGB_CLAIM_NONE 4'h0

`endif

// file: core/mpgb_pkg.sv
/*
  Types of the multi-port GPIO block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package mpgb_pkg;

  // ----------------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------------
  // selected system clock source
  typedef enum logic [1:0] {
    MPGB_CLK_HSI,
    MPGB_CLK_XTAL,
    MPGB_CLK_EXT
  } mpgb_clk_src_t;

  // option fetch state after reset
  typedef enum logic {
    MPGB_OPT_WAIT,
    MPGB_OPT_RUN
  } mpgb_opt_state_t;

endpackage : mpgb_pkg

// file: core/mpgb_sync.sv
/*
  Two-stage synchroniser bank for pin levels.
  Assumes the inputs are asynchronous to core_clk; only the second stage is read.
*/
module mpgb_sync #(
  parameter int W = 14
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // ----------------------------------------------------------------------------
  // two flops
  // ----------------------------------------------------------------------------
  // first flop feeds only the second
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;

endmodule : mpgb_sync

// file: core/mpgb_gpio.sv
/*
  Multi-port GPIO block: nibble port, single-pin port with reset-shared input,
  byte port, pull-ups, analog select and oscillator pin sharing.
  Assumes an 8-bit register port on core_clk, option bits static from storage,
  and pad cells that apply the pin enables.
*/
// What this block does
// RULE1: four-pin port with latch, per-bit direction from nibble direction register
// RULE2: nibble input pins get pull-up when their pull-up bit is set
// RULE3: internal oscillator leaves both oscillator pins free for port or analog
// RULE4: crystal selected claims both oscillator pins; no port, no analog
// RULE5: external clock claims only the oscillator input pin
// RULE6: reset puts all nibble pins in input mode
// RULE7: both oscillator pins are pulled low during reset
// RULE8: nibble pins also carry analog, timer and interrupt functions
// RULE9: single bidirectional pin with latch, direction and pull-up registers
// RULE10: single bidirectional pin also feeds external interrupt one
// RULE11: reset puts the single bidirectional pin in input mode
// RULE12: input-only pin shares reset; option picks port use after power-on
// RULE13: reset-shared pin in port use is ignored as reset source
// RULE14: option read after release; low pin before that keeps reset held
// RULE15: eight-pin port with latch, per-bit direction and pull-ups
// RULE16: reset puts all byte port pins in input mode
// RULE17: fourteen pins, thirteen bidirectional with pull-ups, one input-only
// RULE18: direction bit zero means output driving, one means input
// RULE19: port read gives pin level for inputs, latch for outputs
// RULE20: analog select bit set puts nibble pin in analog mode
// RULE21: usable output pins drive their latch every cycle; nibble pins 0 and 1 drive their latch ORed with tmr_out
`include "mpgb_map.svh"

module mpgb_gpio (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rd_data,
  input wire logic [1:0] opt_clk_sel,
  input wire logic opt_rst_pin_as_port,
  output mpgb_pkg::mpgb_clk_src_t clk_src,
  input wire logic [3:0] nib_pin_in,
  output logic [3:0] nib_pin_out,
  output logic [3:0] nib_pin_oe_n,
  output logic [3:0] nib_pu_en,
  output logic [3:0] nib_ana_en,
  output logic osc_pd_en,
  input wire logic [1:0] tmr_out,
  output logic [3:0] nib_alt_in,
  input wire logic sp_pin_in,
  output logic sp_pin_out,
  output logic sp_pin_oe_n,
  output logic sp_pu_en,
  output logic irq_one_in,
  input wire logic rst_shared_pin_in,
  output logic ext_reset_req,
  output logic core_reset_hold,
  input wire logic [7:0] byte_pin_in,
  output logic [7:0] byte_pin_out,
  output logic [7:0] byte_pin_oe_n,
  output logic [7:0] byte_pu_en
);
  import mpgb_pkg::*;

  // ----------------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------------
  // pin level for inputs, latch for outputs
  function automatic logic [7:0] port_rd(input logic [7:0] dir, input logic [7:0] latch,
                                         input logic [7:0] pin);
    port_rd = (dir & pin) | (~dir & latch); // RULE19
  endfunction : port_rd

  // option code to clock source
  function automatic mpgb_clk_src_t clk_decode(input logic [1:0] code);
    mpgb_clk_src_t src;
    src = MPGB_CLK_HSI;
    if (code == `MPGB_OPT_CLK_XTAL) begin
      src = MPGB_CLK_XTAL;
    end else if (code == `MPGB_OPT_CLK_EXT) begin
      src = MPGB_CLK_EXT;
    end
    clk_decode = src;
  endfunction : clk_decode

  // ----------------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------------
  logic [3:0] nib_latch_r;
  logic [3:0] nib_dir_r;
  logic [3:0] nib_pu_r;
  logic [3:0] ana_sel_r;
  logic sp_latch_r;
  logic sp_dir_r;
  logic sp_pu_r;
  logic [7:0] byte_latch_r;
  logic [7:0] byte_dir_r;
  logic [7:0] byte_pu_r;
  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;
  mpgb_opt_state_t opt_state_r;
  mpgb_clk_src_t clk_src_r;
  logic rst_pin_as_port_r;
  logic osc_pd_r;
  logic ext_req_r;
  logic hold_r;
  logic [3:0] nib_out_r;
  logic [3:0] nib_oe_n_r;
  logic [3:0] nib_pu_en_r;
  logic [3:0] nib_ana_r;
  logic [3:0] nib_alt_r;
  logic sp_out_r;
  logic sp_oe_n_r;
  logic sp_pu_en_r;
  logic irq_one_r;
  logic [7:0] byte_out_r;
  logic [7:0] byte_oe_n_r;
  logic [7:0] byte_pu_en_r;
  logic [13:0] pins_s;

  // ----------------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------------
  mpgb_sync #(.W(14)) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .d({rst_shared_pin_in, sp_pin_in, byte_pin_in, nib_pin_in}),
    .q(pins_s)
  );

  wire [3:0] nib_pin_s = pins_s[3:0];
  wire [7:0] byte_pin_s = pins_s[11:4];
  wire sp_pin_s = pins_s[12];
  wire rst_pin_s = pins_s[13];

  // ----------------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------------
  wire sel_nib_latch = (reg_addr == `MPGB_ADDR_NIB_LATCH);
  wire sel_sp_latch = (reg_addr == `MPGB_ADDR_SP_LATCH);
  wire sel_byte_latch = (reg_addr == `MPGB_ADDR_BYTE_LATCH);
  wire sel_nib_dir = (reg_addr == `MPGB_ADDR_NIB_DIR);
  wire sel_sp_dir = (reg_addr == `MPGB_ADDR_SP_DIR);
  wire sel_byte_dir = (reg_addr == `MPGB_ADDR_BYTE_DIR);
  wire sel_nib_pu = (reg_addr == `MPGB_ADDR_NIB_PU);
  wire sel_sp_pu = (reg_addr == `MPGB_ADDR_SP_PU);
  wire sel_byte_pu = (reg_addr == `MPGB_ADDR_BYTE_PU);
  wire sel_ana = (reg_addr == `MPGB_ADDR_ANA_SEL);

  // ----------------------------------------------------------------------------
  // oscillator pin claim and pin usability
  // ----------------------------------------------------------------------------
  // crystal takes both pins, external clock only the input pin
  wire [3:0] osc_claim = (clk_src_r == MPGB_CLK_XTAL) ? `MPGB_CLAIM_XTAL : // RULE4
                         (clk_src_r == MPGB_CLK_EXT) ? `MPGB_CLAIM_EXT : // RULE5
                         `MPGB_CLAIM_NONE; // RULE3
  wire [3:0] nib_own = ~osc_claim & ~ana_sel_r; // RULE20
  wire [3:0] nib_drv = ~nib_dir_r & nib_own; // RULE18
  wire [7:0] nib_rd_all = port_rd({4'h0, nib_dir_r}, {4'h0, nib_latch_r}, {4'h0, nib_pin_s});
  wire [3:0] nib_rd = nib_rd_all[3:0] & nib_own; // RULE19
  wire sp_drv = ~sp_dir_r; // RULE9
  wire [7:0] byte_drv = ~byte_dir_r; // RULE15
  wire [7:0] sp_rd_all = port_rd({7'h00, sp_dir_r}, {7'h00, sp_latch_r}, {7'h00, sp_pin_s});
  wire sp_rd = sp_rd_all[0]; // RULE19
  wire rst_pin_rd = rst_pin_as_port_r & rst_pin_s; // RULE12

  // ----------------------------------------------------------------------------
  // read data mux
  // ----------------------------------------------------------------------------
  // unimplemented direction bits read one, others zero
  always_comb begin
    rd_data_nxt = 8'h00;
    if (sel_nib_latch) begin
      rd_data_nxt = {4'h0, nib_rd};
    end else if (sel_sp_latch) begin
      rd_data_nxt[`MPGB_SP_IO_BIT] = sp_rd;
      rd_data_nxt[`MPGB_SP_RST_BIT] = rst_pin_rd;
    end else if (sel_byte_latch) begin
      rd_data_nxt = port_rd(byte_dir_r, byte_latch_r, byte_pin_s); // RULE19
    end else if (sel_nib_dir) begin
      rd_data_nxt = {4'hF, nib_dir_r};
    end else if (sel_sp_dir) begin
      rd_data_nxt = 8'hFF;
      rd_data_nxt[`MPGB_SP_IO_BIT] = sp_dir_r;
    end else if (sel_byte_dir) begin
      rd_data_nxt = byte_dir_r;
    end else if (sel_nib_pu) begin
      rd_data_nxt = {4'h0, nib_pu_r};
    end else if (sel_sp_pu) begin
      rd_data_nxt[`MPGB_SP_IO_BIT] = sp_pu_r;
    end else if (sel_byte_pu) begin
      rd_data_nxt = byte_pu_r;
    end else if (sel_ana) begin
      rd_data_nxt = {4'h0, ana_sel_r};
    end
  end

  // read data stands one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_data_r <= 8'h00;
    end else begin
      rd_data_r <= reg_rd ? rd_data_nxt : 8'h00;
    end
  end

  // ----------------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------------
  // nibble port registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      nib_latch_r <= `MPGB_RST_LATCH4;
      nib_dir_r <= `MPGB_RST_DIR4; // RULE6
      nib_pu_r <= `MPGB_RST_PU4;
      ana_sel_r <= `MPGB_RST_ANA4;
    end else if (reg_wr) begin
      if (sel_nib_latch) nib_latch_r <= reg_wr_data[3:0]; // RULE1
      if (sel_nib_dir) nib_dir_r <= reg_wr_data[3:0]; // RULE1
      if (sel_nib_pu) nib_pu_r <= reg_wr_data[3:0]; // RULE2
      if (sel_ana) ana_sel_r <= reg_wr_data[3:0]; // RULE20
    end
  end

  // single-pin port registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sp_latch_r <= 1'b0;
      sp_dir_r <= 1'b1; // RULE11
      sp_pu_r <= 1'b0;
    end else if (reg_wr) begin
      if (sel_sp_latch) sp_latch_r <= reg_wr_data[`MPGB_SP_IO_BIT]; // RULE9
      if (sel_sp_dir) sp_dir_r <= reg_wr_data[`MPGB_SP_IO_BIT]; // RULE9
      if (sel_sp_pu) sp_pu_r <= reg_wr_data[`MPGB_SP_IO_BIT]; // RULE9
    end
  end

  // byte port registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      byte_latch_r <= `MPGB_RST_LATCH8;
      byte_dir_r <= `MPGB_RST_DIR8; // RULE16
      byte_pu_r <= `MPGB_RST_PU8;
    end else if (reg_wr) begin
      if (sel_byte_latch) byte_latch_r <= reg_wr_data; // RULE15
      if (sel_byte_dir) byte_dir_r <= reg_wr_data; // RULE15
      if (sel_byte_pu) byte_pu_r <= reg_wr_data; // RULE15
    end
  end

  // ----------------------------------------------------------------------------
  // option fetch and reset-shared pin
  // ----------------------------------------------------------------------------
  // option is taken only once the shared pin is high after release
  wire opt_take = (opt_state_r == MPGB_OPT_WAIT) && rst_pin_s; // RULE14
  wire ext_req_nxt = (opt_state_r == MPGB_OPT_RUN) && !rst_pin_as_port_r
                     && !rst_pin_s; // RULE13
  wire hold_nxt = ((opt_state_r == MPGB_OPT_WAIT) && !opt_take) || ext_req_nxt; // RULE14

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      opt_state_r <= MPGB_OPT_WAIT;
      clk_src_r <= MPGB_CLK_HSI;
      rst_pin_as_port_r <= 1'b0; // RULE12
    end else if (opt_take) begin
      opt_state_r <= MPGB_OPT_RUN;
      clk_src_r <= clk_decode(opt_clk_sel);
      rst_pin_as_port_r <= opt_rst_pin_as_port; // RULE12
    end
  end

  // reset request, hold and oscillator pin pull-down
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      osc_pd_r <= 1'b1; // RULE7
      ext_req_r <= 1'b0;
      hold_r <= 1'b1;
    end else begin
      osc_pd_r <= 1'b0;
      ext_req_r <= ext_req_nxt;
      hold_r <= hold_nxt;
    end
  end

  // ----------------------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------------------
  // nibble pins: latch or timer output, pull-up only on inputs
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      nib_out_r <= 4'h0;
      nib_oe_n_r <= 4'hF;
      nib_pu_en_r <= 4'h0;
      nib_ana_r <= 4'h0;
      nib_alt_r <= 4'h0;
    end else begin
      nib_out_r <= (nib_latch_r | {2'b00, tmr_out}) & nib_drv; // RULE21 RULE8
      nib_oe_n_r <= ~nib_drv; // RULE1 RULE18
      nib_pu_en_r <= nib_pu_r & nib_dir_r & nib_own; // RULE2
      nib_ana_r <= ana_sel_r & ~osc_claim; // RULE20 RULE4 RULE5
      nib_alt_r <= nib_pin_s & nib_own; // RULE8
    end
  end

  // single pin and byte port
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sp_out_r <= 1'b0;
      sp_oe_n_r <= 1'b1;
      sp_pu_en_r <= 1'b0;
      irq_one_r <= 1'b0;
      byte_out_r <= 8'h00;
      byte_oe_n_r <= 8'hFF;
      byte_pu_en_r <= 8'h00;
    end else begin
      sp_out_r <= sp_latch_r & sp_drv; // RULE21
      sp_oe_n_r <= ~sp_drv; // RULE9 RULE18
      sp_pu_en_r <= sp_pu_r & sp_dir_r; // RULE9 RULE17
      irq_one_r <= sp_pin_s; // RULE10
      byte_out_r <= byte_latch_r & byte_drv; // RULE21
      byte_oe_n_r <= ~byte_drv; // RULE15 RULE18
      byte_pu_en_r <= byte_pu_r & byte_dir_r; // RULE15 RULE17
    end
  end

  // ----------------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------------
  assign reg_rd_data = rd_data_r;
  assign clk_src = clk_src_r;
  assign nib_pin_out = nib_out_r;
  assign nib_pin_oe_n = nib_oe_n_r;
  assign nib_pu_en = nib_pu_en_r;
  assign nib_ana_en = nib_ana_r;
  assign nib_alt_in = nib_alt_r;
  assign osc_pd_en = osc_pd_r;
  assign sp_pin_out = sp_out_r;
  assign sp_pin_oe_n = sp_oe_n_r;
  assign sp_pu_en = sp_pu_en_r;
  assign irq_one_in = irq_one_r;
  assign ext_reset_req = ext_req_r;
  assign core_reset_hold = hold_r;
  assign byte_pin_out = byte_out_r;
  assign byte_pin_oe_n = byte_oe_n_r;
  assign byte_pu_en = byte_pu_en_r;

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_nib_dir_wr;
    reg_wr && sel_nib_dir;
  endsequence

  sequence s_wait_low;
    (opt_state_r == MPGB_OPT_WAIT) && !rst_pin_s;
  endsequence

  AST_NIB_RST_INPUT: assert property ($rose(rst_n) |-> nib_dir_r == 4'hF) // RULE6
    else $error("nibble port not input after reset");
  AST_SP_RST_INPUT: assert property ($rose(rst_n) |-> sp_dir_r && sp_oe_n_r) // RULE11
    else $error("single pin not input after reset");
  AST_BYTE_RST_INPUT: assert property ($rose(rst_n) |-> byte_oe_n_r == 8'hFF) // RULE16
    else $error("byte port not input after reset");
  AST_NIB_DRIVE: assert property (s_nib_dir_wr ##1 $stable(nib_own) |=> // RULE1
      nib_pin_oe_n == ($past(reg_wr_data[3:0], 2) | ~$past(nib_own)))
    else $error("nibble drive does not follow direction write");
  AST_NIB_PU_INPUT_ONLY: assert property (!(|(nib_pu_en & ~$past(nib_dir_r)))) // RULE2
    else $error("pull-up on nibble output pin");
  AST_XTAL_CLAIM: assert property (clk_src_r == MPGB_CLK_XTAL && $stable(clk_src_r) // RULE4
      |-> nib_pin_oe_n[3:2] == 2'b11 && nib_ana_en[3:2] == 2'b00)
    else $error("crystal pins used as port");
  AST_EXT_CLAIM: assert property (clk_src_r == MPGB_CLK_EXT && $stable(clk_src_r) // RULE5
      |-> nib_pin_oe_n[3] && !nib_ana_en[3])
    else $error("external clock pin used as port");
  AST_OSC_PULLDOWN: assert property (disable iff (1'b0) !rst_n |=> osc_pd_en) // RULE7
    else $error("oscillator pins not pulled low in reset");
  AST_HOLD_WAIT: assert property (s_wait_low |=> core_reset_hold) // RULE14
    else $error("reset released while shared pin low");
  AST_PORT_IGNORES_RST: assert property // RULE13
      (opt_state_r == MPGB_OPT_RUN && rst_pin_as_port_r |=> !ext_reset_req)
    else $error("port-mode pin raised reset");
  AST_BYTE_READ: assert property (reg_rd && sel_byte_latch |=> // RULE19
      reg_rd_data == port_rd($past(byte_dir_r), $past(byte_latch_r), $past(byte_pin_s)))
    else $error("byte port read mismatch");
  AST_ANALOG_MODE: assert property (ana_sel_r[0] && $stable(ana_sel_r) |=> // RULE20
      nib_ana_en[0] && nib_pin_oe_n[0])
    else $error("analog pin not in analog mode");

endmodule : mpgb_gpio

// file: testbench/mpgb_pin_model.sv
/*
  Pin-side model: external parts wired to the 13 bidirectional pins.
  Assumes bit order {byte[7:0], single pin, nibble[3:0]} on every vector.
*/
module mpgb_pin_model (
  input wire logic core_clk,
  input wire logic [12:0] pin_out,
  input wire logic [12:0] pin_oe_n,
  input wire logic [12:0] pin_pu,
  input wire logic osc_pd_en,
  input wire logic [12:0] ext_en,
  input wire logic [12:0] ext_val,
  output logic [12:0] pin_lvl
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------------------
  // wire resolution
  // ----------------------------------------------------------------------------
  logic flt_r = 1'h0;

  // an undriven pin wanders every cycle so a stale value never passes
  always @(posedge core_clk) flt_r <= ~flt_r;

  // design drive wins, then external drive, then pull-up, then pull-down
  always_comb begin
    for (int i = 0; i < 13; i++) begin
      if (!pin_oe_n[i]) pin_lvl[i] = pin_out[i];
      else if (ext_en[i]) pin_lvl[i] = ext_val[i];
      else if (pin_pu[i]) pin_lvl[i] = 1'h1;
      else if (osc_pd_en && (i == 2 || i == 3)) pin_lvl[i] = 1'h0;
      else pin_lvl[i] = flt_r ^ i[0];
    end
  end
endmodule : mpgb_pin_model

// file: testbench/tb.sv
/*
  Self-checking bench of the multi-port GPIO block.
  Assumes the pin model above and the register port protocol of the block.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mpgb_pkg::*;

  // ----------------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------------
  logic core_clk, rst_n, reg_wr, reg_rd, opt_rst_pin_as_port, osc_pd_en;
  logic [15:0] reg_addr;
  logic [7:0] reg_wr_data, reg_rd_data, rv;
  logic [1:0] opt_clk_sel, tmr_out;
  mpgb_clk_src_t clk_src;
  logic [3:0] nib_pin_in, nib_pin_out, nib_pin_oe_n, nib_pu_en, nib_ana_en, nib_alt_in;
  logic sp_pin_in, sp_pin_out, sp_pin_oe_n, sp_pu_en, irq_one_in;
  logic rst_shared_pin_in, ext_reset_req, core_reset_hold;
  logic [7:0] byte_pin_in, byte_pin_out, byte_pin_oe_n, byte_pu_en;
  logic [12:0] ext_en, ext_val, lvl;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [3:0] cl [3] = '{4'h0, 4'hC, 4'h8};
  logic [15:0] ra [5] = '{16'hFF22, 16'hFF23, 16'hFF24, 16'hFF33, 16'hFF84};
  logic [7:0] rx [5] = '{8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00};

  // ----------------------------------------------------------------------------
  // instances
  // ----------------------------------------------------------------------------
  mpgb_gpio i_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
    .opt_clk_sel(opt_clk_sel), .opt_rst_pin_as_port(opt_rst_pin_as_port), .clk_src(clk_src),
    .nib_pin_in(nib_pin_in), .nib_pin_out(nib_pin_out), .nib_pin_oe_n(nib_pin_oe_n),
    .nib_pu_en(nib_pu_en), .nib_ana_en(nib_ana_en), .osc_pd_en(osc_pd_en),
    .tmr_out(tmr_out), .nib_alt_in(nib_alt_in), .sp_pin_in(sp_pin_in),
    .sp_pin_out(sp_pin_out), .sp_pin_oe_n(sp_pin_oe_n), .sp_pu_en(sp_pu_en),
    .irq_one_in(irq_one_in), .rst_shared_pin_in(rst_shared_pin_in),
    .ext_reset_req(ext_reset_req), .core_reset_hold(core_reset_hold),
    .byte_pin_in(byte_pin_in), .byte_pin_out(byte_pin_out), .byte_pin_oe_n(byte_pin_oe_n),
    .byte_pu_en(byte_pu_en));

  mpgb_pin_model i_pins (.core_clk(core_clk),
    .pin_out({byte_pin_out, sp_pin_out, nib_pin_out}),
    .pin_oe_n({byte_pin_oe_n, sp_pin_oe_n, nib_pin_oe_n}),
    .pin_pu({byte_pu_en, sp_pu_en, nib_pu_en}), .osc_pd_en(osc_pd_en),
    .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(lvl));

  assign {byte_pin_in, sp_pin_in, nib_pin_in} = lvl;

  // ----------------------------------------------------------------------------
  // clock, timeout and tasks
  // ----------------------------------------------------------------------------
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  // a hang counts as a mismatch
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      end_sim();
    end
  end

  task automatic end_sim;
    if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : wt

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask : wr

  // read, mask and compare; data stand only in the cycle after the strobe
  task automatic rdc(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1 rv = reg_rd_data;
    chk(rv & m, e);
  endtask : rdc

  task automatic drv(input logic [12:0] en, input logic [12:0] v);
    @(posedge core_clk);
    ext_en <= en;
    ext_val <= v;
  endtask : drv

  // reset for six cycles with the given options, then wait for the hold to drop
  task automatic boot(input logic [1:0] cs, input logic as_port);
    int n;
    @(posedge core_clk);
    rst_n <= 1'h0;
    opt_clk_sel <= cs;
    opt_rst_pin_as_port <= as_port;
    wt(5);
    chk({4'h0, nib_pin_oe_n}, 8'h0F);
    chk({7'h0, sp_pin_oe_n}, 8'h01);
    chk(byte_pin_oe_n, 8'hFF);
    chk({7'h0, osc_pd_en}, 8'h01);
    @(posedge core_clk);
    rst_n <= 1'h1;
    n = 0;
    while (core_reset_hold !== 1'h0 && n < 20) begin
      wt(1);
      n++;
    end
    chk({7'h0, core_reset_hold}, 8'h00);
  endtask : boot

  // ----------------------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------------------
  initial begin
    rst_n = 1'h0;
    reg_addr = 16'h0000;
    reg_wr_data = 8'h00;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    opt_clk_sel = 2'h0;
    opt_rst_pin_as_port = 1'h0;
    tmr_out = 2'h0;
    rst_shared_pin_in = 1'h1;
    ext_en = 13'h0000;
    ext_val = 13'h0000;
    // each clock source: external, crystal, internal; internal left last
    for (int m = 2; m >= 0; m--) begin
      boot(m[1:0], 1'h0);
      chk({6'h0, clk_src}, m[7:0]);
      for (int k = 0; k < 5; k++) rdc(ra[k], 8'hFF, rx[k]);
      wr(16'hFF22, 8'h00);
      wr(16'hFF02, 8'h0F);
      wt(2);
      chk({4'h0, nib_pin_oe_n}, {4'h0, cl[m]});
      chk({4'h0, nib_pin_out}, {4'h0, ~cl[m]});
      wr(16'hFF84, 8'h0F);
      wt(2);
      chk({4'h0, nib_ana_en}, {4'h0, ~cl[m]});
    end
    rdc(16'hFF84, 8'hFF, 8'h0F);
    // mixed directions on nibble and byte ports, timer output on bit 1
    wr(16'hFF84, 8'h00);
    wr(16'hFF22, 8'h0C);
    wr(16'hFF02, 8'h01);
    drv({8'hF0, 1'h0, 4'hC}, {8'h30, 1'h0, 4'h8});
    wr(16'hFF24, 8'hF0);
    wr(16'hFF04, 8'hA5);
    @(posedge core_clk) tmr_out <= 2'h2;
    wt(4);
    chk({4'h0, nib_pin_out}, 8'h03);
    chk({4'h0, nib_pin_oe_n}, 8'h0C);
    chk({4'h0, nib_alt_in} & 8'h0C, 8'h08);
    chk(byte_pin_oe_n, 8'hF0);
    chk(byte_pin_out & 8'h0F, 8'h05);
    rdc(16'hFF02, 8'hFF, 8'h09);
    rdc(16'hFF04, 8'hFF, 8'h35);
    // pull-ups only on input pins
    drv(13'h0000, 13'h0000);
    wr(16'hFF32, 8'h0F);
    wr(16'hFF34, 8'hFF);
    wt(4);
    chk({4'h0, nib_pu_en}, 8'h0C);
    chk(byte_pu_en, 8'hF0);
    rdc(16'hFF02, 8'hFF, 8'h0D);
    rdc(16'hFF04, 8'hFF, 8'hF5);
    // single bidirectional pin
    wr(16'hFF03, 8'h04);
    wr(16'hFF23, 8'hFB);
    wt(2);
    chk({6'h0, sp_pin_oe_n, sp_pin_out}, 8'h01);
    wr(16'hFF23, 8'hFF);
    drv(13'h0010, 13'h0000);
    wt(4);
    chk({7'h0, irq_one_in}, 8'h00);
    drv(13'h0010, 13'h0010);
    wt(4);
    chk({7'h0, irq_one_in}, 8'h01);
    rdc(16'hFF03, 8'h04, 8'h04);
    drv(13'h0000, 13'h0000);
    wr(16'hFF33, 8'h04);
    wt(2);
    chk({7'h0, sp_pu_en}, 8'h01);
    // unmapped place: write lost, read zero, data gone a cycle later
    wr(16'hFF10, 8'hAA);
    rdc(16'hFF24, 8'hFF, 8'hF0);
    wt(1);
    chk(reg_rd_data, 8'h00);
    rdc(16'hFF10, 8'hFF, 8'h00);
    // reset-shared pin in reset use, low across release
    @(posedge core_clk) rst_shared_pin_in <= 1'h0;
    wt(4);
    chk({7'h0, ext_reset_req}, 8'h01);
    @(posedge core_clk) rst_n <= 1'h0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'h1;
    wt(10);
    chk({7'h0, core_reset_hold}, 8'h01);
    @(posedge core_clk) rst_shared_pin_in <= 1'h1;
    wt(5);
    chk({7'h0, core_reset_hold}, 8'h00);
    // reset-shared pin in port use
    boot(2'h0, 1'h1);
    @(posedge core_clk) rst_shared_pin_in <= 1'h0;
    wt(4);
    chk({7'h0, ext_reset_req}, 8'h00);
    rdc(16'hFF03, 8'h10, 8'h00);
    @(posedge core_clk) rst_shared_pin_in <= 1'h1;
    wt(3);
    rdc(16'hFF03, 8'h10, 8'h10);
    end_sim();
  end
endmodule : tb
